// ===== rtc_core.sv
// real-time clock with calendar, match alarm, frequency outputs and user bytes
`timescale 1ns/1ns
module rtc_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic xtal_in,
  input wire logic ext_clk_in,
  input wire logic osc_bypass_select,
  input wire logic rtc_enable,
  input wire logic clock_write_unlock,
  input wire logic hour_mode_24,
  input wire logic io_supply_good,
  input wire logic main_clock_supply,
  input wire logic on_backup_supply,
  input wire logic time_wr,
  input wire logic [2:0] time_wr_field,
  input wire logic [7:0] time_wr_data,
  input wire logic user_wr,
  input wire logic user_wr_index,
  input wire logic [7:0] user_wr_data,
  input wire logic [7:0] alarm_sec,
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  input wire logic [7:0] alarm_date,
  input wire logic [7:0] alarm_month,
  input wire logic [7:0] alarm_wday,
  input wire logic alarm_enable,
  input wire logic alarm_repeat_mode,
  input wire logic backup_alarm_enable,
  input wire logic alarm_flag_clear,
  input wire logic status_read,
  input wire logic auto_reset_mode,
  input wire logic [3:0] freq_out_select,
  input wire logic slow_clock_out,
  input wire logic [2:0] slow_clock_select,
  output logic [7:0] time_sec,
  output logic [7:0] time_min,
  output logic [7:0] time_hour,
  output logic [7:0] time_date,
  output logic [7:0] time_month,
  output logic [7:0] time_year,
  output logic [2:0] time_wday,
  output logic [7:0] user_mem0,
  output logic [7:0] user_mem1,
  output logic alarm_flag,
  output logic total_power_fail_flag,
  output logic freq_out_mode,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic multipurpose_pin_two
);
  rtc_pkg::rtc_state_t st;
  rtc_pkg::rtc_state_t next_st;
  logic base_level;
  logic base_tick;
  logic host_ok;
  logic clock_wr;
  logic quarter_tick;
  logic second_tick;
  logic alarm_active;
  logic match_now;
  logic trigger;
  logic [8:0] inc;
  logic [7:0] hr12;
  logic day_carry;

  initial begin
    if (rtc_pkg::QUARTER_TICKS != int'(rtc_pkg::QUARTER_MASK) + 1) begin
      $error("quarter period does not match prescaler mask");
    end
  end

  rtc_time_base u_time_base (
    .clk(clk),
    .sys_rst(sys_rst),
    .xtal_in(xtal_in),
    .ext_clk_in(ext_clk_in),
    .osc_bypass_select(osc_bypass_select),
    .base_level(base_level),
    .base_tick(base_tick)
  );

  // BCD increment with wrap: returns {carry, next}
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    logic [8:0] r;
    r = 9'h000;
    if (v >= hi) begin
      r = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // last date of a month in BCD, leap every fourth year of 00..99
  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    logic [7:0] d;
    leap = (~y[4] & (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) |
           (y[4] & (y[3:0] == 4'h2 || y[3:0] == 4'h6));
    d = 8'h31;
    case (m)
      8'h02: d = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
      default: d = 8'h31;
    endcase
    return d;
  endfunction

  // one alarm field matches when disabled or equal
  function automatic logic field_ok(input logic [7:0] a, input logic [7:0] t, input logic [6:0] m);
    return ~a[rtc_pkg::ALARM_EN_BIT] | ((a[6:0] & m) == (t[6:0] & m));
  endfunction

  // prescaler bit that carries a given interrupt pin frequency code
  function automatic logic fo_level(input logic [3:0] code, input logic [19:0] p,
                                    input logic base);
    logic lv;
    lv = 1'b1;
    case (code)
      4'h0: lv = 1'b1;
      4'h1: lv = base;
      4'h2: lv = p[2];
      4'h3: lv = p[4];
      default: lv = p[5'(code) + 5'h04];
    endcase
    return lv;
  endfunction

  // host access gating, clock tick derivation and alarm conditions
  assign host_ok = io_supply_good & main_clock_supply;
  assign clock_wr = time_wr & host_ok & clock_write_unlock;
  assign quarter_tick = base_tick & ((st.prescale & rtc_pkg::QUARTER_MASK) ==
                                      rtc_pkg::QUARTER_MASK);
  assign second_tick = base_tick & ((st.prescale & rtc_pkg::SECOND_MASK) ==
                                     rtc_pkg::SECOND_MASK);
  assign alarm_active = alarm_enable & (freq_out_select == rtc_pkg::FO_OFF) &
                        (~on_backup_supply | backup_alarm_enable);
  assign match_now = alarm_active &
                     (alarm_sec[rtc_pkg::ALARM_EN_BIT] | alarm_min[rtc_pkg::ALARM_EN_BIT] |
                      alarm_hour[rtc_pkg::ALARM_EN_BIT] | alarm_date[rtc_pkg::ALARM_EN_BIT] |
                      alarm_month[rtc_pkg::ALARM_EN_BIT] | alarm_wday[rtc_pkg::ALARM_EN_BIT]) &
                     field_ok(alarm_sec, st.sec, 7'h7F) & field_ok(alarm_min, st.min, 7'h7F) &
                     field_ok(alarm_hour, st.hour, 7'h3F) & field_ok(alarm_date, st.date, 7'h3F) &
                     field_ok(alarm_month, st.month, 7'h1F) &
                     field_ok(alarm_wday, {5'h00, st.wday}, 7'h07);
  assign trigger = match_now & ~st.match_prev;

  // next state: counting, writes, alarm and pin drive
  always_comb begin
    next_st = st;
    inc = 9'h000;
    hr12 = 8'h00;
    day_carry = 1'b0;
    if (base_tick) begin
      next_st.prescale = st.prescale + 20'h00001;
    end
    // time and calendar advance on the second tick once loaded
    if (second_tick & rtc_enable & st.started) begin
      inc = bcd_inc(st.sec, 8'h00, rtc_pkg::MAX_SEC);
      next_st.sec = inc[7:0];
      if (inc[8]) begin
        inc = bcd_inc(st.min, 8'h00, rtc_pkg::MAX_SEC);
        next_st.min = inc[7:0];
        if (inc[8]) begin
          if (hour_mode_24) begin
            inc = bcd_inc(st.hour, 8'h00, rtc_pkg::MAX_HOUR24);
            next_st.hour = inc[7:0];
            day_carry = inc[8];
          end else begin
            hr12 = {3'h0, st.hour[4:0]};
            if (hr12 == 8'h12) begin
              next_st.hour = {st.hour[7:6], st.hour[rtc_pkg::HOUR_PM_BIT], 5'h01};
            end else if (hr12 == 8'h11) begin
              next_st.hour = {st.hour[7:6], ~st.hour[rtc_pkg::HOUR_PM_BIT], 5'h12};
              day_carry = st.hour[rtc_pkg::HOUR_PM_BIT];
            end else begin
              inc = bcd_inc(hr12, 8'h01, 8'h12);
              next_st.hour = {st.hour[7:5], inc[4:0]};
            end
          end
          if (day_carry) begin
            next_st.wday = (st.wday >= rtc_pkg::MAX_WDAY) ? 3'h0 : st.wday + 3'h1;
            inc = bcd_inc(st.date, 8'h01, month_last(st.month, st.year));
            next_st.date = inc[7:0];
            if (inc[8]) begin
              inc = bcd_inc(st.month, 8'h01, rtc_pkg::MAX_MONTH);
              next_st.month = inc[7:0];
              if (inc[8]) begin
                inc = bcd_inc(st.year, 8'h00, rtc_pkg::MAX_YEAR);
                next_st.year = inc[7:0];
              end
            end
          end
        end
      end
    end
    // host writes into the clock group win over the tick
    if (clock_wr) begin
      next_st.started = 1'b1;
      next_st.power_fail = 1'b0;
      case (time_wr_field)
        rtc_pkg::FIELD_SEC: next_st.sec = time_wr_data;
        rtc_pkg::FIELD_MIN: next_st.min = time_wr_data;
        rtc_pkg::FIELD_HOUR: next_st.hour = time_wr_data;
        rtc_pkg::FIELD_DATE: next_st.date = time_wr_data;
        rtc_pkg::FIELD_MONTH: next_st.month = time_wr_data;
        rtc_pkg::FIELD_YEAR: next_st.year = time_wr_data;
        rtc_pkg::FIELD_WDAY: next_st.wday = time_wr_data[2:0];
        default: next_st.started = 1'b1;
      endcase
    end
    // retained user bytes
    if (user_wr & host_ok) begin
      if (user_wr_index) begin
        next_st.user1 = user_wr_data;
      end else begin
        next_st.user0 = user_wr_data;
      end
    end
    // alarm flag: clear ignored while matching, set wins over clear
    next_st.match_prev = match_now;
    if (host_ok & ~match_now & (alarm_flag_clear | (status_read & auto_reset_mode))) begin
      next_st.alarm_flag = 1'b0;
    end
    if (trigger) begin
      next_st.alarm_flag = 1'b1;
      next_st.pulse_pending = alarm_repeat_mode;
    end
    // in alarm mode the interrupt pin state advances only on quarter-second boundaries
    if (quarter_tick) begin
      if (alarm_repeat_mode) begin
        next_st.int_low = st.pulse_pending;
        next_st.pulse_pending = trigger & alarm_repeat_mode;
      end else begin
        next_st.int_low = st.alarm_flag;
        next_st.pulse_pending = 1'b0;
      end
    end
    // pin drive: frequency when a code is set, else alarm request
    if (freq_out_select != rtc_pkg::FO_OFF) begin
      next_st.int_drive = ~fo_level(freq_out_select, next_st.prescale, base_level);
      next_st.int_low = 1'b0;
    end else begin
      next_st.int_drive = next_st.int_low;
    end
    // multipurpose pin slow clock
    if (!slow_clock_out) begin
      next_st.mpio_level = 1'b0;
    end else if (slow_clock_select == 3'h0) begin
      next_st.mpio_level = base_level;
    end else begin
      next_st.mpio_level = next_st.prescale[slow_clock_select - 3'h1];
    end
  end

  // state register with power-up values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.sec <= rtc_pkg::RST_SEC;
      st.min <= rtc_pkg::RST_MIN;
      st.hour <= rtc_pkg::RST_HOUR;
      st.date <= rtc_pkg::RST_DATE;
      st.month <= rtc_pkg::RST_MONTH;
      st.year <= rtc_pkg::RST_YEAR;
      st.wday <= rtc_pkg::RST_WDAY;
      st.power_fail <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register, except the frequency mode flag and the pin data
  assign time_sec = st.sec;
  assign time_min = st.min;
  assign time_hour = st.hour;
  assign time_date = st.date;
  assign time_month = st.month;
  assign time_year = st.year;
  assign time_wday = st.wday;
  assign user_mem0 = st.user0;
  assign user_mem1 = st.user1;
  assign alarm_flag = st.alarm_flag;
  assign total_power_fail_flag = st.power_fail;
  assign freq_out_mode = (freq_out_select != rtc_pkg::FO_OFF);
  assign irq_n_out = 1'b0; // open drain, only ever pulls low
  assign irq_n_oe = st.int_drive;
  assign multipurpose_pin_two = st.mpio_level;
endmodule

// ===== rtc_pkg.sv
// shared constants and state types of the real-time clock core
package rtc_pkg;
  localparam int BASE_HZ = 32768;
  localparam int QUARTER_MS = 250;
  localparam int QUARTER_TICKS = BASE_HZ * QUARTER_MS / 1000;
  localparam int PRESCALE_W = 20;
  localparam logic [PRESCALE_W-1:0] QUARTER_MASK = 20'h01FFF;
  localparam logic [PRESCALE_W-1:0] SECOND_MASK = 20'h07FFF;
  localparam logic [2:0] FIELD_SEC = 3'h0;
  localparam logic [2:0] FIELD_MIN = 3'h1;
  localparam logic [2:0] FIELD_HOUR = 3'h2;
  localparam logic [2:0] FIELD_DATE = 3'h3;
  localparam logic [2:0] FIELD_MONTH = 3'h4;
  localparam logic [2:0] FIELD_YEAR = 3'h5;
  localparam logic [2:0] FIELD_WDAY = 3'h6;
  localparam int HOUR_PM_BIT = 5;
  localparam int ALARM_EN_BIT = 7;
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [2:0] RST_WDAY = 3'h0;
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR24 = 8'h23;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [2:0] MAX_WDAY = 3'h6;
  localparam logic [3:0] FO_OFF = 4'h0;
  localparam logic [3:0] FO_BASE = 4'h1;

  typedef struct packed {
    logic level;
    logic tick;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [2:0] wday;
    logic [PRESCALE_W-1:0] prescale;
    logic started;
    logic power_fail;
    logic alarm_flag;
    logic match_prev;
    logic pulse_pending;
    logic int_low;
    logic int_drive;
    logic mpio_level;
    logic [7:0] user0;
    logic [7:0] user1;
  } rtc_state_t;
endpackage

// ===== rtc_time_base.sv
// selects crystal or external 32.768 kHz source and marks its rising edges
`timescale 1ns/1ns
module rtc_time_base (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic xtal_in,
  input wire logic ext_clk_in,
  input wire logic osc_bypass_select,
  output logic base_level,
  output logic base_tick
);
  rtc_pkg::sync_state_t st;
  rtc_pkg::sync_state_t next_st;

  // source choice and edge detection
  always_comb begin
    next_st = st;
    next_st.level = osc_bypass_select ? ext_clk_in : xtal_in;
    next_st.tick = next_st.level & ~st.level;
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign base_level = st.level;
  assign base_tick = st.tick;
endmodule

// ===== rtc_checker.sv
// assertion checker on the real-time clock core ports
`timescale 1ns/1ns
module rtc_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic io_supply_good,
  input wire logic main_clock_supply,
  input wire logic clock_write_unlock,
  input wire logic time_wr,
  input wire logic [2:0] time_wr_field,
  input wire logic [7:0] time_wr_data,
  input wire logic user_wr,
  input wire logic user_wr_index,
  input wire logic [7:0] user_wr_data,
  input wire logic alarm_flag_clear,
  input wire logic status_read,
  input wire logic auto_reset_mode,
  input wire logic [3:0] freq_out_select,
  input wire logic slow_clock_out,
  input wire logic [7:0] time_sec,
  input wire logic [7:0] user_mem1,
  input wire logic alarm_flag,
  input wire logic total_power_fail_flag,
  input wire logic freq_out_mode,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic multipurpose_pin_two
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // strobes act only while both supplies are good
  logic host_ok;
  logic clk_wr;
  assign host_ok = io_supply_good & main_clock_supply;
  assign clk_wr = host_ok & time_wr & clock_write_unlock;
  a_user_store: assert property (host_ok && user_wr && user_wr_index
    |=> user_mem1 == $past(user_wr_data)) else $error("user byte not stored");
  a_io_refuse: assert property (user_wr && !io_supply_good
    |=> $stable(user_mem1)) else $error("write taken with io supply low");
  a_uvlo_refuse: assert property (user_wr && !main_clock_supply
    |=> $stable(user_mem1)) else $error("write taken below lockout");
  a_sec_write: assert property (clk_wr && time_wr_field == rtc_pkg::FIELD_SEC
    |=> time_sec == $past(time_wr_data)) else $error("seconds write lost");
  a_time_frozen: assert property (total_power_fail_flag && !time_wr
    |=> $stable(time_sec)) else $error("time moved before first write");
  a_fail_clear: assert property (clk_wr |=> !total_power_fail_flag)
    else $error("power fail flag kept after clock write");
  a_flag_hold: assert property (alarm_flag && !alarm_flag_clear
    && !(status_read && auto_reset_mode) |=> alarm_flag) else $error("flag dropped");
  a_irq_hold: assert property ($rose(irq_n_oe) && !freq_out_mode && !$past(freq_out_mode)
    && !$past(freq_out_mode, 2) |=> irq_n_oe [*8]) else $error("interrupt pin released early");
  a_mode_pin: assert property (freq_out_mode == (freq_out_select != rtc_pkg::FO_OFF))
    else $error("frequency mode flag wrong");
  a_pin_data: assert property (irq_n_out == 1'h0) else $error("open drain data not low");
  a_mpio_off: assert property (!slow_clock_out |=> !multipurpose_pin_two)
    else $error("multipurpose pin active while off");
endmodule
bind rtc_core rtc_checker rtc_checker_inst (.clk, .sys_rst, .io_supply_good,
  .main_clock_supply, .clock_write_unlock, .time_wr, .time_wr_field, .time_wr_data, .user_wr,
  .user_wr_index, .user_wr_data, .alarm_flag_clear, .status_read, .auto_reset_mode,
  .freq_out_select, .slow_clock_out, .time_sec, .user_mem1, .alarm_flag, .total_power_fail_flag,
  .freq_out_mode, .irq_n_out, .irq_n_oe, .multipurpose_pin_two);

// ===== time_src.sv
// time base sources: crystal always runs, external clock can be stopped
`timescale 1ns/1ns
module time_src (
  input wire logic clk,
  input wire logic ext_run,
  output logic xtal_in,
  output logic ext_clk_in
);
  // toggle each falling edge, far faster than a real crystal to keep runs short
  initial begin
    xtal_in = 1'h0;
    ext_clk_in = 1'h0;
  end
  always @(negedge clk) begin
    xtal_in <= ~xtal_in;
    if (ext_run) ext_clk_in <= ~ext_clk_in;
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the real-time clock core
`timescale 1ns/1ns
module tb_top;
  logic clk, sys_rst, osc_bypass_select, rtc_enable, clock_write_unlock, hour_mode_24;
  logic io_supply_good, main_clock_supply, on_backup_supply, time_wr, user_wr, user_wr_index;
  logic alarm_enable, alarm_repeat_mode, backup_alarm_enable, alarm_flag_clear, status_read;
  logic auto_reset_mode, slow_clock_out, ext_run, xtal_in, ext_clk_in, alarm_flag, irq_n_out;
  logic total_power_fail_flag, freq_out_mode, irq_n_oe, multipurpose_pin_two;
  logic [2:0] time_wr_field, slow_clock_select, time_wday;
  logic [3:0] freq_out_select;
  logic [7:0] time_wr_data, user_wr_data, alarm_sec, alarm_min, alarm_hour, alarm_date;
  logic [7:0] alarm_month, alarm_wday, time_sec, time_min, time_hour, time_date, time_month;
  logic [7:0] time_year, user_mem0, user_mem1;
  int num_errors, num_checks, cycles, n;
  int fo_hz[4] = '{32768, 4096, 1024, 64};
  logic [7:0] setv[7] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h23, 8'h06};
  time_src time_src_inst (.clk, .ext_run, .xtal_in, .ext_clk_in);
  rtc_core rtc_core_inst (.clk, .sys_rst, .xtal_in, .ext_clk_in, .osc_bypass_select,
    .rtc_enable, .clock_write_unlock, .hour_mode_24, .io_supply_good, .main_clock_supply,
    .on_backup_supply, .time_wr, .time_wr_field, .time_wr_data, .user_wr, .user_wr_index,
    .user_wr_data, .alarm_sec, .alarm_min, .alarm_hour, .alarm_date, .alarm_month, .alarm_wday,
    .alarm_enable, .alarm_repeat_mode, .backup_alarm_enable, .alarm_flag_clear, .status_read,
    .auto_reset_mode, .freq_out_select, .slow_clock_out, .slow_clock_select, .time_sec,
    .time_min, .time_hour, .time_date, .time_month, .time_year, .time_wday, .user_mem0,
    .user_mem1, .alarm_flag, .total_power_fail_flag, .freq_out_mode, .irq_n_out, .irq_n_oe,
    .multipurpose_pin_two);
  // clock and hang guard
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 105000) begin
        num_errors++;
        conclude();
      end
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic put_time(input logic [2:0] f, input logic [7:0] d);
    @(negedge clk);
    time_wr = 1'h1;
    time_wr_field = f;
    time_wr_data = d;
    @(negedge clk);
    time_wr = 1'h0;
  endtask
  task automatic put_user(input logic i, input logic [7:0] d);
    @(negedge clk);
    user_wr = 1'h1;
    user_wr_index = i;
    user_wr_data = d;
    @(negedge clk);
    user_wr = 1'h0;
  endtask
  task automatic clear_flag(input logic rd);
    @(negedge clk);
    if (rd) status_read = 1'h1;
    else alarm_flag_clear = 1'h1;
    @(negedge clk);
    status_read = 1'h0;
    alarm_flag_clear = 1'h0;
  endtask
  // cycles between two rising edges of the chosen pin, 0 if it stays still
  task automatic measure(input logic pick, output int per);
    logic prev, cur;
    int first;
    first = -1;
    per = 0;
    prev = 1'h1;
    for (int k = 0; k < 2100 && per == 0; k++) begin
      @(negedge clk);
      cur = pick ? multipurpose_pin_two : irq_n_oe;
      if (cur === 1'h1 && prev === 1'h0) begin
        if (first < 0) first = k;
        else per = k - first;
      end
      prev = cur;
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    num_errors = 0;
    num_checks = 0;
    sys_rst = 1'h1;
    {osc_bypass_select, rtc_enable, clock_write_unlock, on_backup_supply, time_wr} = '0;
    {user_wr, user_wr_index, alarm_enable, alarm_repeat_mode, backup_alarm_enable} = '0;
    {alarm_flag_clear, status_read, auto_reset_mode, slow_clock_out, ext_run} = '0;
    {hour_mode_24, io_supply_good, main_clock_supply} = 3'h7;
    {time_wr_field, slow_clock_select, freq_out_select, time_wr_data, user_wr_data} = '0;
    {alarm_sec, alarm_min, alarm_hour, alarm_date, alarm_month, alarm_wday} = '0;
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    repeat (50) @(negedge clk);
    chk(time_sec, rtc_pkg::RST_SEC, "sec after reset");
    chk(time_date, rtc_pkg::RST_DATE, "date after reset");
    chk(total_power_fail_flag, 1'h1, "fail flag after reset");
    chk(irq_n_oe, 1'h0, "pin idle");
    // refused strobes, then accepted user bytes
    io_supply_good = 1'h0;
    put_user(1'h0, 8'hA5);
    chk(user_mem0, 8'h00, "write with io low");
    io_supply_good = 1'h1;
    main_clock_supply = 1'h0;
    put_user(1'h1, 8'h5A);
    chk(user_mem1, 8'h00, "write below lockout");
    main_clock_supply = 1'h1;
    put_time(rtc_pkg::FIELD_SEC, 8'h30);
    chk(time_sec, 8'h00, "locked time write");
    put_user(1'h0, 8'hA5);
    put_user(1'h1, 8'h5A);
    chk(user_mem0, 8'hA5, "user byte 0");
    chk(user_mem1, 8'h5A, "user byte 1");
    rtc_enable = 1'h1;
    clock_write_unlock = 1'h1;
    // interrupt pin as clock output, base runs at half the clk rate
    for (int c = 1; c <= 4; c++) begin
      freq_out_select = 4'(c);
      measure(1'h0, n);
      chk(16'(n), 16'(2 * rtc_pkg::BASE_HZ / fo_hz[c-1]), "pin clock period");
      chk(freq_out_mode, 1'h1, "frequency mode");
    end
    freq_out_select = rtc_pkg::FO_BASE;
    osc_bypass_select = 1'h1;
    measure(1'h0, n);
    chk(16'(n), 16'h0000, "stopped external source");
    ext_run = 1'h1;
    measure(1'h0, n);
    chk(16'(n), 16'h0002, "external source");
    osc_bypass_select = 1'h0;
    freq_out_select = rtc_pkg::FO_OFF;
    slow_clock_out = 1'h1;
    for (int s = 0; s < 4; s++) begin
      slow_clock_select = 3'(s);
      measure(1'h1, n);
      chk(16'(n), 16'(2 << s), "multipurpose clock period");
    end
    slow_clock_out = 1'h0;
    chk(freq_out_mode, 1'h0, "alarm mode");
    // 23:59:59 on the last day of February in a common year, seconds last
    for (int f = 6; f >= 0; f--) put_time(3'(f), setv[f]);
    chk(total_power_fail_flag, 1'h0, "fail flag after write");
    chk(time_hour, 8'h23, "hour written");
    chk(time_wday, 3'h6, "weekday written");
    alarm_sec = 8'h80;
    alarm_min = 8'h45;
    alarm_enable = 1'h1;
    for (int k = 0; k < 70000 && time_sec === 8'h59; k++) @(negedge clk);
    @(negedge clk);
    chk({time_hour, time_min}, 16'h0000, "midnight rollover");
    chk({time_month, time_date}, 16'h0301, "month rollover");
    chk({time_year, 5'h00, time_wday}, 16'h2300, "year and weekday");
    chk(alarm_flag, 1'h1, "seconds match");
    chk(irq_n_oe, 1'h0, "pin waits for quarter");
    clear_flag(1'h0);
    chk(alarm_flag, 1'h1, "clear during match");
    for (int k = 0; k < 17000 && irq_n_oe !== 1'h1; k++) @(negedge clk);
    chk(irq_n_oe, 1'h1, "one-shot pin low");
    alarm_enable = 1'h0;
    repeat (4) @(negedge clk);
    clear_flag(1'h0);
    chk(alarm_flag, 1'h0, "clear by write");
    chk(irq_n_oe, 1'h1, "pin holds after clear");
    alarm_enable = 1'h1;
    repeat (3) @(negedge clk);
    chk(alarm_flag, 1'h1, "match on enable");
    alarm_enable = 1'h0;
    clear_flag(1'h1);
    chk(alarm_flag, 1'h1, "read without auto reset");
    auto_reset_mode = 1'h1;
    clear_flag(1'h1);
    chk(alarm_flag, 1'h0, "read with auto reset");
    // battery gating, then a periodic trigger whose pin pulse outlives the flag
    on_backup_supply = 1'h1;
    alarm_repeat_mode = 1'h1;
    alarm_enable = 1'h1;
    repeat (3) @(negedge clk);
    chk(alarm_flag, 1'h0, "alarm gated on battery");
    backup_alarm_enable = 1'h1;
    repeat (3) @(negedge clk);
    chk(alarm_flag, 1'h1, "alarm on battery enabled");
    alarm_enable = 1'h0;
    repeat (4) @(negedge clk);
    clear_flag(1'h0);
    chk(alarm_flag, 1'h0, "periodic flag cleared");
    repeat (16400) @(negedge clk);
    chk(irq_n_oe, 1'h1, "periodic pulse after clear");
    conclude();
  end
endmodule
